// ===== src/tbdr_pkg.sv
// Package for the bypass data-register scan port.
// Assumes nothing: constants and types shared by the port's files only.
package tbdr_pkg;

   // ------------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------------
   localparam int unsigned IR_W     = 8;      // Instruction register width
   localparam int unsigned DR_W     = 8;      // Test data register width

   // ------------------------------------------------------------------
   // Codes and capture values
   // ------------------------------------------------------------------
   localparam logic [IR_W-1:0] IR_CAPTURE   = 8'h81; // Loaded at Capture-IR
   localparam logic [IR_W-1:0] INSTR_BYPASS = 8'hFF; // All ones: bypass
   localparam logic [IR_W-1:0] INSTR_DATA   = 8'h0E; // Selects data register
   localparam logic            BYP_CAPTURE  = 1'b0;  // Bypass capture level
   localparam logic [DR_W-1:0] DR_RESET     = 8'h00; // Data register reset

   // ------------------------------------------------------------------
   // Controller states
   // ------------------------------------------------------------------
   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR,
      UPD_DR, SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR,
      UPD_IR
   } tbdr_state_t;

endpackage : tbdr_pkg

// ===== src/tbdr_sync.sv
// Three-stage synchroniser with agreement filter, W bits wide.
// Assumes d comes from another clock domain and each bit is independent.
`timescale 1ns/1ps
`default_nettype none

module tbdr_sync #(
   parameter int unsigned W = 1              // Number of bits carried
) (
   // Clock and reset
   input  wire  logic         clk,
   input  wire  logic         rst,
   // Foreign level and its settled copy
   input  wire  logic [W-1:0] d,
   output logic       [W-1:0] q
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [W-1:0] s1;                     // First stage, read by s2 only
      logic [W-1:0] s2;                     // Second stage
      logic [W-1:0] s3;                     // Third stage
      logic [W-1:0] q;                      // Settled output
   } tbdr_sync_t;

   tbdr_sync_t st_r;                         // Registered state
   tbdr_sync_t st_nxt;                       // Next state

   // Shift chain; output follows once stages two and three agree
   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      for (int i = 0; i < W; i++) begin
         if (st_r.s2[i] == st_r.s3[i]) begin
            st_nxt.q[i] = st_r.s3[i];
         end
      end
   end

   // Register with asynchronous clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.q;

endmodule // tbdr_sync

`default_nettype wire

// ===== src/tbdr_tap.sv
// Test access port with bypass stage and one selectable data register.
// Assumes tck, tms and tdi come from a boundary-scan controller; the
// controller changes tms and tdi on falling tck. Core side runs on clk.
//
// What this block does
// - Capture-DR exit loads zero into bypass stage
// - Drive tdo from falling edge in Shift-DR
// - First tdi bit sampled leaving first Shift-DR
// - Bypass is one-stage delay from tdi to tdo
// - Exit1-DR falling edge releases tdo to high-z
// - Update-DR falling edge loads selected output stage
// - State advances on rising tck using tms
// - All-ones instruction selects the bypass path
`timescale 1ns/1ps
`default_nettype none

module tbdr_tap (
   // Core clock, reset and freeze
   input  wire  logic                     clk,
   input  wire  logic                     rst,
   input  wire  logic                     ce,
   // Test access port
   input  wire  logic                     tck,
   input  wire  logic                     tms,
   input  wire  logic                     tdi,
   output logic                           tdo_o,
   output logic                           tdo_oe,
   // Core-side view of the scan logic
   output logic [tbdr_pkg::DR_W-1:0]      dr_word,
   output logic                           dr_upd_pulse,
   output logic                           bypass_sel
);

   // ------------------------------------------------------------------
   // State types
   // ------------------------------------------------------------------
   typedef struct packed {
      tbdr_pkg::tbdr_state_t        st;       // Controller state
      logic [tbdr_pkg::IR_W-1:0]    ir_sh;    // Instruction shift stage
      logic                         byp;      // Bypass stage
      logic [tbdr_pkg::DR_W-1:0]    dr_sh;    // Data shift stage
   } tbdr_rise_t;

   typedef struct packed {
      logic [tbdr_pkg::IR_W-1:0]    ir;       // Active instruction
      logic [tbdr_pkg::DR_W-1:0]    dr_out;   // Data output stage
      logic                         tdo;      // Serial output
      logic                         oe;       // Serial output enable
      logic                         upd_tgl;  // Flips on each data update
   } tbdr_fall_t;

   typedef struct packed {
      logic                         tgl_seen; // Last toggle level taken
      logic [tbdr_pkg::DR_W-1:0]    word;     // Copy of output stage
      logic                         pulse;    // One-cycle update marker
      logic                         byp_lvl;  // Bypass path selected
   } tbdr_core_t;

   tbdr_rise_t rise_r;                        // Rising-edge state
   tbdr_rise_t rise_nxt;                      // Its next value
   tbdr_fall_t fall_r;                        // Falling-edge state
   tbdr_fall_t fall_nxt;                      // Its next value
   tbdr_core_t core_r;                        // Core-domain state
   tbdr_core_t core_nxt;                      // Its next value

   logic       ce_t;                          // Freeze level in tck domain
   logic       byp_path;                      // Bypass currently selected
   logic [1:0] to_core;                       // Toggle, inverted bypass

   // Any code other than the data-register one uses the bypass stage
   assign byp_path = (fall_r.ir != tbdr_pkg::INSTR_DATA);

   // ------------------------------------------------------------------
   // Crossings
   // ------------------------------------------------------------------
   // Freeze level into the link clock domain
   tbdr_sync #(.W(1)) u_ce_sync (
      .clk (tck),
      .rst (rst),
      .d   (ce),
      .q   (ce_t)
   );

   // Update toggle and path select into the core domain; the path bit
   // travels inverted so the cleared synchroniser already means bypass
   // and bypass_sel shows no false low just after reset
   tbdr_sync #(.W(2)) u_core_sync (
      .clk (clk),
      .rst (rst),
      .d   ({fall_r.upd_tgl, ~byp_path}),
      .q   (to_core)
   );

   // ------------------------------------------------------------------
   // Rising tck: controller and shift stages
   // ------------------------------------------------------------------
   always_comb begin
      rise_nxt = rise_r;
      if (ce_t) begin
         // Next controller state from sampled tms
         case (rise_r.st)
            tbdr_pkg::TLR:      rise_nxt.st = tms ? tbdr_pkg::TLR
                                                  : tbdr_pkg::RTI;
            tbdr_pkg::RTI:      rise_nxt.st = tms ? tbdr_pkg::SEL_DR
                                                  : tbdr_pkg::RTI;
            tbdr_pkg::SEL_DR:   rise_nxt.st = tms ? tbdr_pkg::SEL_IR
                                                  : tbdr_pkg::CAP_DR;
            tbdr_pkg::CAP_DR:   rise_nxt.st = tms ? tbdr_pkg::EXIT1_DR
                                                  : tbdr_pkg::SHIFT_DR;
            tbdr_pkg::SHIFT_DR: rise_nxt.st = tms ? tbdr_pkg::EXIT1_DR
                                                  : tbdr_pkg::SHIFT_DR;
            tbdr_pkg::EXIT1_DR: rise_nxt.st = tms ? tbdr_pkg::UPD_DR
                                                  : tbdr_pkg::PAUSE_DR;
            tbdr_pkg::PAUSE_DR: rise_nxt.st = tms ? tbdr_pkg::EXIT2_DR
                                                  : tbdr_pkg::PAUSE_DR;
            tbdr_pkg::EXIT2_DR: rise_nxt.st = tms ? tbdr_pkg::UPD_DR
                                                  : tbdr_pkg::SHIFT_DR;
            tbdr_pkg::UPD_DR:   rise_nxt.st = tms ? tbdr_pkg::SEL_DR
                                                  : tbdr_pkg::RTI;
            tbdr_pkg::SEL_IR:   rise_nxt.st = tms ? tbdr_pkg::TLR
                                                  : tbdr_pkg::CAP_IR;
            tbdr_pkg::CAP_IR:   rise_nxt.st = tms ? tbdr_pkg::EXIT1_IR
                                                  : tbdr_pkg::SHIFT_IR;
            tbdr_pkg::SHIFT_IR: rise_nxt.st = tms ? tbdr_pkg::EXIT1_IR
                                                  : tbdr_pkg::SHIFT_IR;
            tbdr_pkg::EXIT1_IR: rise_nxt.st = tms ? tbdr_pkg::UPD_IR
                                                  : tbdr_pkg::PAUSE_IR;
            tbdr_pkg::PAUSE_IR: rise_nxt.st = tms ? tbdr_pkg::EXIT2_IR
                                                  : tbdr_pkg::PAUSE_IR;
            tbdr_pkg::EXIT2_IR: rise_nxt.st = tms ? tbdr_pkg::UPD_IR
                                                  : tbdr_pkg::SHIFT_IR;
            tbdr_pkg::UPD_IR:   rise_nxt.st = tms ? tbdr_pkg::SEL_DR
                                                  : tbdr_pkg::RTI;
            default:            rise_nxt.st = tbdr_pkg::TLR;
         endcase
         // Capture and shift actions of the state being left
         case (rise_r.st)
            tbdr_pkg::CAP_DR: begin
               rise_nxt.byp   = tbdr_pkg::BYP_CAPTURE;
               rise_nxt.dr_sh = fall_r.dr_out;
            end
            tbdr_pkg::SHIFT_DR: begin
               rise_nxt.byp   = tdi;
               rise_nxt.dr_sh = {tdi, rise_r.dr_sh[tbdr_pkg::DR_W-1:1]};
            end
            tbdr_pkg::CAP_IR: begin
               rise_nxt.ir_sh = tbdr_pkg::IR_CAPTURE;
            end
            tbdr_pkg::SHIFT_IR: begin
               rise_nxt.ir_sh = {tdi, rise_r.ir_sh[tbdr_pkg::IR_W-1:1]};
            end
            default: begin
               rise_nxt.byp   = rise_r.byp;
            end
         endcase
      end
   end

   // Rising-edge register
   always_ff @(posedge tck or posedge rst) begin
      if (rst) begin
         rise_r <= '{st: tbdr_pkg::TLR, ir_sh: tbdr_pkg::IR_CAPTURE,
                     byp: tbdr_pkg::BYP_CAPTURE, dr_sh: tbdr_pkg::DR_RESET};
      end else begin
         rise_r <= rise_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Falling tck: serial output and update stages
   // ------------------------------------------------------------------
   always_comb begin
      fall_nxt = fall_r;
      if (ce_t) begin
         // Output is driven only while a shift state is held
         fall_nxt.oe = (rise_r.st == tbdr_pkg::SHIFT_DR) ||
                       (rise_r.st == tbdr_pkg::SHIFT_IR);
         case (rise_r.st)
            tbdr_pkg::SHIFT_DR: begin
               fall_nxt.tdo = byp_path ? rise_r.byp
                                       : rise_r.dr_sh[0];
            end
            tbdr_pkg::SHIFT_IR: begin
               fall_nxt.tdo = rise_r.ir_sh[0];
            end
            tbdr_pkg::UPD_DR: begin
               if (!byp_path) begin
                  fall_nxt.dr_out  = rise_r.dr_sh;
                  fall_nxt.upd_tgl = ~fall_r.upd_tgl;
               end
            end
            tbdr_pkg::UPD_IR: begin
               fall_nxt.ir = rise_r.ir_sh;
            end
            tbdr_pkg::TLR: begin
               fall_nxt.ir = tbdr_pkg::INSTR_BYPASS;
            end
            default: begin
               fall_nxt.tdo = fall_r.tdo;
            end
         endcase
      end
   end

   // Falling-edge register
   always_ff @(negedge tck or posedge rst) begin
      if (rst) begin
         fall_r <= '{ir: tbdr_pkg::INSTR_BYPASS, dr_out: tbdr_pkg::DR_RESET,
                     tdo: 1'b0, oe: 1'b0, upd_tgl: 1'b0};
      end else begin
         fall_r <= fall_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Core clock: take updated word once the toggle has settled
   // ------------------------------------------------------------------
   always_comb begin
      core_nxt = core_r;
      if (ce) begin
         core_nxt.pulse   = 1'b0;
         core_nxt.byp_lvl = ~to_core[0];
         // Output stage is stable long before the settled toggle arrives
         if (to_core[1] != core_r.tgl_seen) begin
            core_nxt.tgl_seen = to_core[1];
            core_nxt.word     = fall_r.dr_out;
            core_nxt.pulse    = 1'b1;
         end
      end
   end

   // Core register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         core_r <= '{tgl_seen: 1'b0, word: tbdr_pkg::DR_RESET,
                     pulse: 1'b0, byp_lvl: 1'b1};
      end else begin
         core_r <= core_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign tdo_o        = fall_r.tdo;
   assign tdo_oe       = fall_r.oe;
   assign dr_word      = core_r.word;
   assign dr_upd_pulse = core_r.pulse;
   assign bypass_sel   = core_r.byp_lvl;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   byp_capture_a: assert property (
      @(posedge tck) disable iff (rst)
      (ce_t && rise_r.st == tbdr_pkg::CAP_DR) |=> !rise_r.byp)
      else $error("bypass stage did not capture zero");

   oe_enable_a: assert property (
      @(negedge tck) disable iff (rst)
      (ce_t && rise_r.st == tbdr_pkg::SHIFT_DR) |=> tdo_oe)
      else $error("tdo not driven in Shift-DR");

   tdi_sample_a: assert property (
      @(posedge tck) disable iff (rst)
      (ce_t && rise_r.st == tbdr_pkg::SHIFT_DR)
         |=> rise_r.byp == $past(tdi))
      else $error("tdi not sampled into bypass stage");

   byp_delay_a: assert property (
      @(posedge tck) disable iff (rst)
      (ce_t && $past(ce_t) && byp_path &&
       rise_r.st == tbdr_pkg::SHIFT_DR &&
       $past(rise_r.st) == tbdr_pkg::SHIFT_DR) |-> tdo_o == $past(tdi))
      else $error("bypass path is not a one-stage delay");

   oe_release_a: assert property (
      @(negedge tck) disable iff (rst)
      (ce_t && rise_r.st == tbdr_pkg::EXIT1_DR) |=> !tdo_oe)
      else $error("tdo not released in Exit1-DR");

   dr_update_a: assert property (
      @(negedge tck) disable iff (rst)
      (ce_t && !byp_path && rise_r.st == tbdr_pkg::UPD_DR)
         |=> fall_r.dr_out == $past(rise_r.dr_sh))
      else $error("output stage not updated in Update-DR");

   tap_step_a: assert property (
      @(posedge tck) disable iff (rst)
      (ce_t && rise_r.st == tbdr_pkg::SHIFT_DR && tms)
         |=> rise_r.st == tbdr_pkg::EXIT1_DR)
      else $error("controller did not leave Shift-DR on tms high");

   bypass_pick_a: assert property (
      @(negedge tck) disable iff (rst)
      (ce_t && rise_r.st == tbdr_pkg::UPD_IR &&
       rise_r.ir_sh == tbdr_pkg::INSTR_BYPASS) |=> byp_path)
      else $error("all-ones code did not select bypass");

endmodule // tbdr_tap

`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench for the bypass data-register scan port.
// Assumes the controller model drives the link; core clock is 50 MHz.
`timescale 1ns/1ps
`default_nettype none

module tb;
   // ------------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------------
   logic                      clk;          // Core clock
   logic                      rst;          // Async reset
   logic                      ce;           // Freeze control
   wire logic                 tck;          // Link clock from model
   wire logic                 tms;          // Mode select
   wire logic                 tdi;          // Serial in
   logic                      tdo_o;        // Serial out level
   logic                      tdo_oe;       // Serial out enable
   wire logic                 tdo_w;        // Resolved serial wire
   logic [tbdr_pkg::DR_W-1:0] dr_word;      // Core copy of data reg
   logic                      dr_upd_pulse; // Update strobe
   logic                      bypass_sel;   // Bypass selected
   int                        err_total;    // Mismatches
   int                        n_checks;     // Comparisons
   int                        pulses;       // Update strobes seen
   logic [7:0]                d;            // Scan output word
   logic                      pre;          // Wire before shift
   logic                      rel;          // Wire at Exit1
   logic                      s;            // Spare sample

   // A released one-bit wire as seen through the 8-bit compare
   localparam logic [7:0]     HI_Z = {7'h00, 1'bz};

   // Wire is floating unless the port drives it
   assign tdo_w = tdo_oe ? tdo_o : 1'bz;

   // ------------------------------------------------------------------
   // Instances
   // ------------------------------------------------------------------
   tbdr_tap i_tbdr_tap (
      .clk(clk), .rst(rst), .ce(ce), .tck(tck), .tms(tms), .tdi(tdi),
      .tdo_o(tdo_o), .tdo_oe(tdo_oe), .dr_word(dr_word),
      .dr_upd_pulse(dr_upd_pulse), .bypass_sel(bypass_sel)
   );
   tbdr_ctrl_model ctrl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_w));

   // Core clock
   initial clk = 1'b0;
   always #10 clk = ~clk;

   // Count update strobes
   always @(posedge clk) begin
      if (dr_upd_pulse === 1'b1) begin
         pulses <= pulses + 1;
      end
   end

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic finish_test;
      $display("checks=%0d errors=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   // Reset values, bypass chosen after reset
   task automatic t_reset;
      #1;
      check(tdo_oe, 8'h00);
      check(dr_word, tbdr_pkg::DR_RESET);
      check(dr_upd_pulse, 8'h00);
      check(bypass_sel, 8'h01);
      #7;
      repeat (5) ctrl.idle(1'b1, s);
   endtask

   // Bypass scan: 101 in gives 010 out, no data register update
   task automatic t_bypass;
      int p0;
      p0 = pulses;
      ctrl.scan(1'b0, 1'b1, 3, 8'h05, d, pre, rel);
      check(pre, HI_Z);
      check(d[2:0], 8'h02);
      check(rel, HI_Z);
      check(8'(pulses), 8'(p0));
   endtask

   // Data register selected, two scans, then bypass again; the scans
   // park in Run-Test/Idle because the reset state reloads bypass
   task automatic t_data;
      int p0;
      ctrl.scan(1'b1, 1'b0, 8, tbdr_pkg::INSTR_DATA, d, pre, rel);
      check(d, tbdr_pkg::IR_CAPTURE);
      repeat (10) @(posedge clk);
      check(bypass_sel, 8'h00);
      p0 = pulses;
      ctrl.scan(1'b0, 1'b0, 8, 8'hA5, d, pre, rel);
      check(d, tbdr_pkg::DR_RESET);
      check(8'(pulses), 8'(p0 + 1));
      check(dr_word, 8'hA5);
      ctrl.scan(1'b0, 1'b0, 8, 8'h3C, d, pre, rel);
      check(d, 8'hA5);
      check(dr_word, 8'h3C);
      check(rel, HI_Z);
      ctrl.scan(1'b1, 1'b0, 8, tbdr_pkg::INSTR_BYPASS, d, pre, rel);
      repeat (10) @(posedge clk);
      check(bypass_sel, 8'h01);
      repeat (3) ctrl.idle(1'b1, s);
   endtask

   // Frozen port ignores tck, then resumes; the freeze level reaches
   // the link domain only after four tck rises, given with tms high
   task automatic t_freeze;
      @(posedge clk) ce <= 1'b0;
      repeat (10) @(posedge clk);
      #7;
      repeat (4) ctrl.idle(1'b1, s);
      ctrl.idle(1'b0, s);
      ctrl.idle(1'b1, s);
      ctrl.idle(1'b0, s);
      ctrl.idle(1'b0, s);
      ctrl.idle(1'b0, s);
      check(s, HI_Z);
      @(posedge clk) ce <= 1'b1;
      repeat (10) @(posedge clk);
      repeat (8) ctrl.idle(1'b1, s);
      t_bypass();
   endtask

   // ------------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------------
   initial begin
      err_total = 0;
      n_checks = 0;
      pulses = 0;
      rst = 1'b1;
      ce = 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      t_reset();
      t_bypass();
      t_data();
      t_bypass();
      t_freeze();
      finish_test();
   end

   // Hang guard
   initial begin
      #1000000;
      err_total++;
      finish_test();
   end
endmodule // tb

`default_nettype wire

// ===== verification/tbdr_ctrl_model.sv
// Behavioural boundary-scan controller facing the scan port.
// Assumes the bench calls its tasks; tck stands low outside frames.
`timescale 1ns/1ps
`default_nettype none

module tbdr_ctrl_model (
   // Link to the port
   output var logic tck,
   output var logic tms,
   output var logic tdi,
   input  wire logic tdo
);
   // ------------------------------------------------------------------
   // Idle levels
   // ------------------------------------------------------------------
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end

   // One tck period: levels change after the fall, taken on the rise
   task automatic step(input logic m, input logic d, output logic seen);
      tms = m;
      tdi = d;
      #80 tck = 1'b1;
      #80 tck = 1'b0;
      #1 seen = tdo;
   endtask

   // Period with tdi unused: it flips so a stale level never helps
   task automatic idle(input logic m, output logic seen);
      step(m, ~tdi, seen);
   endtask

   // Full scan from reset state or Run-Test/Idle, LSB first
   // fin high ends in the reset state, low parks in Run-Test/Idle so the
   // loaded instruction survives for the next scan
   task automatic scan(input logic ir, input logic fin, input int n,
                       input logic [7:0] din,
                       output logic [7:0] dout, output logic pre,
                       output logic rel);
      logic s;
      dout = 8'h00;
      #7;
      idle(1'b0, s);
      idle(1'b1, s);
      if (ir) begin
         idle(1'b1, s);
      end
      idle(1'b0, pre);               // Capture state, port still released
      idle(1'b0, s);                 // Shift entered, first bit out
      dout[0] = s;
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], s);
         if (i < n - 1) begin
            dout[i + 1] = s;
         end else begin
            rel = s;                 // Exit1 reached
         end
      end
      idle(1'b1, s);                 // Update
      if (fin) begin
         repeat (3) idle(1'b1, s);
      end else begin
         idle(1'b0, s);              // Park in Run-Test/Idle
      end
   endtask
endmodule // tbdr_ctrl_model

`default_nettype wire
